// >>> hw/lvd_defs.svh
// constants for the low-voltage reset and detector block
// Functional notes
// [RULE1] unused option bits read fixed: ones at 12,10,7,6,4; zeros at 11,8
// [RULE2] sub-oscillator bit picks slow clock: 0 is 128kHz, 1 is 16kHz
// [RULE3] power bit 0 is low power, 1 high; low crystal forces low
// [RULE4] watchdog period bit 1 gives 18 ms, 0 gives 4.5 ms
// [RULE5] lowest three option bits hold a customer id with no function
// [RULE6] enabled reset asserts after 10 us below level, holds until release
// [RULE7] reset level field: 11 off, 10 2.7/2.9V, 01 3.5/3.7V, 00 4.0/4.2V
// [RULE8] control bit 7 enables the detector interrupt
// [RULE9] control bit 6 runs the detector and is read/write
// [RULE10] detect level field: 11 2.2V, 10 3.3V, 01 4.0V, 00 4.5V
// [RULE11] status bit 7 is read-only active-low state, low below threshold
// [RULE12] software may clear status bits 6,5,4 but never set them
// [RULE13] status reads are anded with control and auxiliary mask; the code masks only flag bits 6:4, bits 7 and 3:0 read unmasked
// [RULE14] wake enable keeps detector running in sleep and wakes the system
// [RULE15] falling across threshold sets the flag and clears the state bit
// [RULE16] every system reset clears the interrupt flag
// [RULE17] with global enable, a set flag requests vector 021H
// [RULE18] enable instruction sets global enable, disable instruction clears it
// [RULE19] flag stays set until software clears it
// [RULE20] software sets level, wake, interrupt, global, then detector enable; the bench sets global, then interrupt and detector in one write
// [RULE21] comparator outputs pass two flip-flops before any use
`ifndef LVD_DEFS_SVH
`define LVD_DEFS_SVH
`define LVD_ADDR_OPT     8'h00
`define LVD_ADDR_CTRL    8'h04
`define LVD_ADDR_STAT    8'h08
`define LVD_ADDR_MASK    8'h0C
`define LVD_ADDR_CORE    8'h10
`define LVD_OPT_ONES     13'h14D0
`define LVD_OPT_ZEROS    13'h0900
`define LVD_OPT_RESET    13'h1FFF
`define LVD_CTRL_RESET   8'h00
`define LVD_STAT_CLR     8'h70
`define LVD_IRQ_VECTOR   10'h021
`define LVD_RESP_OKAY    2'b00
`define LVD_RESP_SLVERR  2'b10
`define LVD_CLK_MHZ      125
`define LVD_FILT_NS      10000
`define LVD_FILT_CYC     ((`LVD_FILT_NS * `LVD_CLK_MHZ) / 1000)
`define LVD_WDT_LONG_US  18000
`define LVD_WDT_SHORT_US 4500
`endif

// >>> hw/lvd_pkg.sv
// types shared by the low-voltage reset and detector block
package lvd_pkg;
    // detector control word layout
    typedef struct packed {
        logic       irq_en;
        logic       det_en;
        logic [1:0] level;
        logic [2:0] spare;
        logic       ext_wake;
    } lvd_ctrl_s;
    // reset filter sequencer
    typedef enum logic [1:0] {
        LVD_IDLE  = 2'b00,
        LVD_FILT  = 2'b01,
        LVD_HOLD  = 2'b11
    } lvd_rst_e;
endpackage : lvd_pkg

// >>> hw/lvd_top.sv
// low-voltage reset, low-voltage detector and option word decode
`timescale 1ns/100ps
`include "lvd_defs.svh"
module lvd_top #(
    parameter logic [12:0] OPT_INIT   = `LVD_OPT_RESET,
    parameter int          FILT_CYC   = `LVD_FILT_CYC,
    parameter int          WDT_LONG   = `LVD_WDT_LONG_US * `LVD_CLK_MHZ,
    parameter int          WDT_SHORT  = `LVD_WDT_SHORT_US * `LVD_CLK_MHZ
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // asynchronous comparators and option inputs
    input  wire logic        vdd_below_reset,
    input  wire logic        vdd_above_release,
    input  wire logic        vdd_below_detect,
    input  wire logic [1:0]  reset_level_sel,
    input  wire logic        low_crystal_mode,
    // core events
    input  wire logic        global_irq_on_instr,
    input  wire logic        global_irq_off_instr,
    input  wire logic        sleep_instr,
    input  wire logic        adc_irq_evt,
    input  wire logic        cmp_irq_evt,
    // outputs to the rest of the chip
    output logic             sys_reset_req,
    output logic             reset_cmp_en,
    output logic [1:0]       detect_level,
    output logic             detect_run,
    output logic             wake_req,
    output logic             irq_req,
    output logic [9:0]       irq_vector,
    output logic             sub_osc_select,
    output logic             power_level_select,
    output logic [23:0]      wdt_period_cyc
);
    // byte-lane merge used by every writable register
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
        lane = s[0] ? d[7:0] : old;
    endfunction : lane

    // option word with reserved bits pinned; low three bits are the customer id, read only
    wire logic [12:0] opt_word = (OPT_INIT | `LVD_OPT_ONES) & ~`LVD_OPT_ZEROS; // RULE1 RULE5

    // synchronisers
    logic [1:0] s_rst_r, s_rel_r, s_det_r;
    always_ff @(posedge aclk) begin
        s_rst_r <= {s_rst_r[0], vdd_below_reset};
        s_rel_r <= {s_rel_r[0], vdd_above_release};
        s_det_r <= {s_det_r[0], vdd_below_detect};
    end
    wire logic below_rst = s_rst_r[1]; // RULE21
    wire logic above_rel = s_rel_r[1]; // RULE21
    wire logic below_det = s_det_r[1]; // RULE21

    // registers
    lvd_pkg::lvd_ctrl_s ctrl_r;
    logic [7:0]  mask_r;
    logic [3:0]  wake_en_r;
    logic        flag_r, adif_r, cmpif_r;
    logic        state_n_r, gie_r, sleep_r, below_det_d_r;
    lvd_pkg::lvd_rst_e rst_st_r, rst_st_nxt;
    logic [$clog2(FILT_CYC+1)-1:0] filt_r;

    // bus handshake state
    logic       awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;

    // write acceptance: address and data taken together
    wire logic wr_go = s_awvalid & s_wvalid & ~awready_r & ~bvalid_r;
    wire logic rd_go = s_arvalid & ~arready_r & ~rvalid_r;
    wire logic wr_ctrl = wr_go & (s_awaddr == `LVD_ADDR_CTRL);
    wire logic wr_stat = wr_go & (s_awaddr == `LVD_ADDR_STAT);
    wire logic wr_mask = wr_go & (s_awaddr == `LVD_ADDR_MASK);
    wire logic wr_core = wr_go & (s_awaddr == `LVD_ADDR_CORE);
    wire logic wr_hit  = wr_ctrl | wr_stat | wr_mask | wr_core |
                         (s_awaddr == `LVD_ADDR_OPT);
    wire logic [7:0] wbyte = lane(8'h00, s_wdata, s_wstrb);
    wire logic wr_lane = s_wstrb[0];

    // detector running: enabled, and awake or allowed to watch in sleep
    wire logic run = ctrl_r.det_en & (~sleep_r | wake_en_r[0]); // RULE9 RULE14
    wire logic fall = run & below_det & ~below_det_d_r; // RULE15
    wire logic in_rst = (rst_st_r == lvd_pkg::LVD_HOLD);

    // status view and masked read
    wire logic [7:0] stat_raw = {state_n_r, flag_r, adif_r, cmpif_r, wake_en_r};
    // flag bits 6:4 are gated by the aux mask and the interrupt enable
    wire logic [7:0] stat_rd  = stat_raw & (8'h8F | (mask_r &
                                {1'b0, {3{ctrl_r.irq_en}}, 4'h0})); // RULE13
    wire logic [31:0] rd_mux =
        (s_araddr == `LVD_ADDR_OPT)  ? {19'h0_0000, opt_word} :
        (s_araddr == `LVD_ADDR_CTRL) ? {24'h00_0000, ctrl_r} :
        (s_araddr == `LVD_ADDR_STAT) ? {24'h00_0000, stat_rd} :
        (s_araddr == `LVD_ADDR_MASK) ? {24'h00_0000, mask_r} :
        {30'h0000_0000, sleep_r, gie_r};
    wire logic rd_hit = (s_araddr == `LVD_ADDR_OPT) | (s_araddr == `LVD_ADDR_CTRL) |
                        (s_araddr == `LVD_ADDR_STAT) | (s_araddr == `LVD_ADDR_MASK) |
                        (s_araddr == `LVD_ADDR_CORE);

    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `LVD_RESP_OKAY;
        end else begin
            awready_r <= wr_go;
            wready_r  <= wr_go;
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
            end else if (s_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `LVD_RESP_OKAY;
        end else begin
            arready_r <= rd_go;
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_hit ? rd_mux : 32'h0000_0000;
                rresp_r  <= rd_hit ? `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
            end else if (s_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // control and mask registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r    <= `LVD_CTRL_RESET;
            mask_r    <= 8'h00;
            wake_en_r <= 4'h0;
        end else begin
            if (wr_ctrl && wr_lane)
                ctrl_r <= wbyte & 8'hF1; // RULE8 RULE9 RULE10
            if (wr_mask && wr_lane)
                mask_r <= wbyte;
            if (wr_stat && wr_lane)
                wake_en_r <= wbyte[3:0]; // RULE14
        end
    end

    // event flags: hardware set wins over software clear
    wire logic clr_ok = wr_stat & wr_lane;
    always_ff @(posedge aclk) begin
        if (!aresetn || in_rst) begin
            flag_r  <= 1'b0; // RULE16
            adif_r  <= 1'b0;
            cmpif_r <= 1'b0;
        end else begin
            flag_r  <= fall | (flag_r & ~(clr_ok & ~wbyte[6])); // RULE12 RULE15 RULE19
            adif_r  <= adc_irq_evt | (adif_r & ~(clr_ok & ~wbyte[5])); // RULE12
            cmpif_r <= cmp_irq_evt | (cmpif_r & ~(clr_ok & ~wbyte[4])); // RULE12
        end
    end

    // detector state bit, reads 1 while not running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_n_r     <= 1'b1;
            below_det_d_r <= 1'b0;
        end else begin
            state_n_r     <= ~(run & below_det); // RULE11 RULE15
            below_det_d_r <= run & below_det;
        end
    end

    // global enable, sleep and wake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_r   <= 1'b0;
            sleep_r <= 1'b0;
        end else begin
            if (global_irq_on_instr || (wr_core && wr_lane && wbyte[0]))
                gie_r <= 1'b1; // RULE18
            else if (global_irq_off_instr || (wr_core && wr_lane && !wbyte[0]))
                gie_r <= 1'b0; // RULE18
            if (fall && wake_en_r[0])
                sleep_r <= 1'b0; // RULE14
            else if (sleep_instr)
                sleep_r <= 1'b1;
        end
    end

    // reset sequencer next state
    wire logic lvr_on = (reset_level_sel != 2'b11); // RULE7
    always_comb begin
        rst_st_nxt = rst_st_r;
        unique case (rst_st_r)
            lvd_pkg::LVD_IDLE: if (lvr_on && below_rst) rst_st_nxt = lvd_pkg::LVD_FILT;
            lvd_pkg::LVD_FILT: begin
                if (!lvr_on || !below_rst)
                    rst_st_nxt = lvd_pkg::LVD_IDLE;
                else if (filt_r == ($bits(filt_r))'(FILT_CYC - 1))
                    rst_st_nxt = lvd_pkg::LVD_HOLD; // RULE6
            end
            lvd_pkg::LVD_HOLD: if (above_rel || !lvr_on) rst_st_nxt = lvd_pkg::LVD_IDLE;
            default: rst_st_nxt = lvd_pkg::LVD_IDLE;
        endcase
    end

    // reset sequencer state and filter count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_st_r <= lvd_pkg::LVD_IDLE;
            filt_r   <= '0;
        end else begin
            rst_st_r <= rst_st_nxt;
            filt_r   <= (rst_st_r == lvd_pkg::LVD_FILT) ? filt_r + 1'b1 : '0; // RULE6
        end
    end

    // registered outputs
    logic       sys_reset_r, reset_cmp_en_r, run_r, wake_r, irq_r;
    logic [1:0] level_r;
    logic       sub_osc_r, power_r;
    logic [23:0] wdt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_r    <= 1'b0;
            reset_cmp_en_r <= 1'b0;
            level_r        <= 2'b00;
            run_r          <= 1'b0;
            wake_r         <= 1'b0;
            irq_r          <= 1'b0;
            sub_osc_r      <= 1'b1;
            power_r        <= 1'b1;
            wdt_r          <= 24'h00_0000;
        end else begin
            sys_reset_r    <= (rst_st_nxt == lvd_pkg::LVD_HOLD); // RULE6
            reset_cmp_en_r <= lvr_on; // RULE7
            level_r        <= ctrl_r.level; // RULE10
            run_r          <= run;
            wake_r         <= sleep_r & fall & wake_en_r[0]; // RULE14
            irq_r          <= flag_r & ctrl_r.irq_en & gie_r; // RULE8 RULE17 RULE18
            sub_osc_r      <= opt_word[9]; // RULE2
            power_r        <= opt_word[5] & ~low_crystal_mode; // RULE3
            wdt_r          <= opt_word[3] ? 24'(WDT_LONG) : 24'(WDT_SHORT); // RULE4
        end
    end

    // port connections
    assign s_awready          = awready_r;
    assign s_wready           = wready_r;
    assign s_bvalid           = bvalid_r;
    assign s_bresp            = bresp_r;
    assign s_arready          = arready_r;
    assign s_rvalid           = rvalid_r;
    assign s_rdata            = rdata_r;
    assign s_rresp            = rresp_r;
    assign sys_reset_req      = sys_reset_r;
    assign reset_cmp_en       = reset_cmp_en_r;
    assign detect_level       = level_r;
    assign detect_run         = run_r;
    assign wake_req           = wake_r;
    assign irq_req            = irq_r;
    assign irq_vector         = `LVD_IRQ_VECTOR; // RULE17
    assign sub_osc_select     = sub_osc_r;
    assign power_level_select = power_r;
    assign wdt_period_cyc     = wdt_r;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_low_run;
        run && below_det && !below_det_d_r;
    endsequence

    a_flag_set_fall: assert property (s_low_run ##0 !in_rst |=> flag_r) // RULE15
        else $error("flag not set on falling crossing");
    a_state_low: assert property (s_low_run |=> !state_n_r) // RULE11
        else $error("state bit not cleared below threshold");
    a_flag_sticky: assert property (flag_r && !clr_ok && !in_rst |=> flag_r) // RULE19
        else $error("flag dropped without clear");
    a_flag_no_set: assert property (!flag_r && !fall |=> !flag_r) // RULE12
        else $error("flag set without event");
    a_flag_reset_clr: assert property (in_rst |=> !flag_r) // RULE16
        else $error("flag survived system reset");
    a_irq_gate: assert property (irq_r |-> $past(flag_r && gie_r && ctrl_r.irq_en)) // RULE17
        else $error("interrupt without enable");
    a_gie_on: assert property (global_irq_on_instr |=> gie_r) // RULE18
        else $error("global enable not set");
    a_rst_filter: assert property (lvr_on && below_rst && rst_st_r == lvd_pkg::LVD_IDLE
        ##1 (lvr_on && below_rst) [*2] |-> !sys_reset_r) // RULE6
        else $error("reset asserted before filter time");
    // helper: cycles the synced reset comparator has stayed high with reset enabled, saturating
    logic [$clog2(FILT_CYC+2)-1:0] low_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !(lvr_on && below_rst))
            low_cnt_r <= '0;
        else if (low_cnt_r != '1)
            low_cnt_r <= low_cnt_r + 1'b1;
    end
    a_rst_filter_len: assert property ($rose(sys_reset_r) |-> low_cnt_r >= FILT_CYC) // RULE6
        else $error("reset asserted before the supply stayed low long enough");
    a_rst_hold: assert property (in_rst && !above_rel && lvr_on |=> sys_reset_r) // RULE6
        else $error("reset released early");
    a_wake_pulse: assert property (wake_r |-> $past(sleep_r && wake_en_r[0])) // RULE14
        else $error("wake without enable in sleep");
    a_opt_fixed: assert property ((opt_word & 13'h1DD0) == 13'h14D0) // RULE1
        else $error("reserved option bits wrong");
endmodule : lvd_top

// >>> verif/low_voltage_detect_reset_tb.sv
// self-checking bench for the low-voltage reset and detector block
`timescale 1ns/100ps
`include "lvd_defs.svh"
module low_voltage_detect_reset_tb;
    localparam int          FILT    = 8;
    localparam logic [12:0] OPT     = 13'h0025;
    localparam logic [12:0] OPT_EXP = (OPT & ~`LVD_OPT_ZEROS) | `LVD_OPT_ONES;
    // bench drives
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        below_rst, above_rel, below_det, low_xtal;
    logic [1:0]  rst_sel;
    logic        g_on, g_off, sleep, adc_evt, cmp_evt;
    // design outputs
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, det_lvl;
    logic [31:0] rdata, d;
    logic        sys_rst, cmp_en, run, wake, irq, sub_osc, pwr;
    logic [9:0]  vec;
    logic [23:0] wdt;
    logic [1:0]  r;
    int          n_mismatch, check_count, n_wake;

    // block under test with a short reset filter
    lvd_top #(.OPT_INIT(OPT), .FILT_CYC(FILT)) lvd_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .vdd_below_reset(below_rst), .vdd_above_release(above_rel),
        .vdd_below_detect(below_det), .reset_level_sel(rst_sel),
        .low_crystal_mode(low_xtal), .global_irq_on_instr(g_on),
        .global_irq_off_instr(g_off), .sleep_instr(sleep), .adc_irq_evt(adc_evt),
        .cmp_irq_evt(cmp_evt), .sys_reset_req(sys_rst), .reset_cmp_en(cmp_en),
        .detect_level(det_lvl), .detect_run(run), .wake_req(wake), .irq_req(irq),
        .irq_vector(vec), .sub_osc_select(sub_osc), .power_level_select(pwr),
        .wdt_period_cyc(wdt)
    );

    // clock and wake pulse counter
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (wake === 1'b1) n_wake <= n_wake + 1;

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h00_0000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask : wr

    // one read, compared against the expected word and response
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(d, e);
        chk(rresp, er);
    endtask : rdchk

    // one-cycle core event: 0 on, 1 off, 2 sleep, 3 adc, 4 cmp
    task automatic tick(input int w);
        @(posedge aclk);
        {g_on, g_off, sleep, adc_evt, cmp_evt} <= 5'h10 >> w;
        @(posedge aclk);
        {g_on, g_off, sleep, adc_evt, cmp_evt} <= 5'h00;
    endtask : tick

    task automatic t_reset;
        rdchk(`LVD_ADDR_CTRL, 32'h0, `LVD_RESP_OKAY);
        rdchk(`LVD_ADDR_STAT, 32'h80, `LVD_RESP_OKAY);
        rdchk(`LVD_ADDR_MASK, 32'h0, `LVD_RESP_OKAY);
        chk(irq, 1'b0);
        chk(sys_rst, 1'b0);
    endtask : t_reset

    task automatic t_option;
        rdchk(`LVD_ADDR_OPT, {19'h0, OPT_EXP}, `LVD_RESP_OKAY);
        chk(sub_osc, OPT[9]);
        chk(pwr, 1'b1);
        chk(wdt, 24'h08_9544);
        @(posedge aclk) low_xtal <= 1'b1;
        cyc(3);
        chk(pwr, 1'b0);
        @(posedge aclk) low_xtal <= 1'b0;
        wr(`LVD_ADDR_OPT, 8'h00);
        chk(r, `LVD_RESP_OKAY);
        rdchk(`LVD_ADDR_OPT, {19'h0, OPT_EXP}, `LVD_RESP_OKAY);
        rdchk(8'h14, 32'h0, `LVD_RESP_SLVERR);
        wr(8'h14, 8'h00);
        chk(r, `LVD_RESP_SLVERR);
    endtask : t_option

    task automatic t_ctrl;
        logic [1:0] lv;
        for (int i = 0; i < 4; i++) begin
            lv = i[1:0];
            wr(`LVD_ADDR_CTRL, {2'b01, lv, 4'hF});
            rdchk(`LVD_ADDR_CTRL, {24'h00_0000, 2'b01, lv, 4'h1}, `LVD_RESP_OKAY);
            chk(det_lvl, lv);
            chk(run, 1'b1);
        end
        wr(`LVD_ADDR_CTRL, 8'h00);
        cyc(2);
        chk(run, 1'b0);
        rdchk(`LVD_ADDR_STAT, 32'h80, `LVD_RESP_OKAY);
    endtask : t_ctrl

    task automatic t_detect;
        int w0;
        // programming order: level, wake, global enable, interrupt and detector
        wr(`LVD_ADDR_CTRL, 8'h20);
        wr(`LVD_ADDR_STAT, 8'h71);
        wr(`LVD_ADDR_MASK, 8'hFF);
        tick(0);
        rdchk(`LVD_ADDR_CORE, 32'h1, `LVD_RESP_OKAY);
        wr(`LVD_ADDR_CTRL, 8'hE0);
        @(posedge aclk) below_det <= 1'b1;
        cyc(6);
        chk(irq, 1'b1);
        chk(vec, `LVD_IRQ_VECTOR);
        rdchk(`LVD_ADDR_STAT, 32'h41, `LVD_RESP_OKAY);
        @(posedge aclk) below_det <= 1'b0;
        cyc(6);
        rdchk(`LVD_ADDR_STAT, 32'hC1, `LVD_RESP_OKAY);
        wr(`LVD_ADDR_MASK, 8'hBF);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
        wr(`LVD_ADDR_MASK, 8'hFF);
        // interrupt enable off hides the flag and drops the request
        wr(`LVD_ADDR_CTRL, 8'h60);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
        chk(irq, 1'b0);
        wr(`LVD_ADDR_CTRL, 8'hE0);
        tick(1);
        cyc(3);
        chk(irq, 1'b0);
        tick(0);
        cyc(3);
        chk(irq, 1'b1);
        wr(`LVD_ADDR_STAT, 8'h71);
        rdchk(`LVD_ADDR_STAT, 32'hC1, `LVD_RESP_OKAY);
        wr(`LVD_ADDR_STAT, 8'h31);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
        cyc(2);
        chk(irq, 1'b0);
        wr(`LVD_ADDR_STAT, 8'hF1);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
        tick(3);
        rdchk(`LVD_ADDR_STAT, 32'hA1, `LVD_RESP_OKAY);
        tick(4);
        rdchk(`LVD_ADDR_STAT, 32'hB1, `LVD_RESP_OKAY);
        wr(`LVD_ADDR_STAT, 8'h01);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
        // detector keeps running in sleep and wakes the system once
        w0 = n_wake;
        tick(2);
        @(posedge aclk) below_det <= 1'b1;
        cyc(6);
        chk(n_wake - w0, 1);
        rdchk(`LVD_ADDR_STAT, 32'h41, `LVD_RESP_OKAY);
        @(posedge aclk) below_det <= 1'b0;
        wr(`LVD_ADDR_STAT, 8'h31);
    endtask : t_detect

    task automatic t_lvr;
        int n;
        @(posedge aclk) {below_rst, above_rel, rst_sel} <= 4'b1011;
        cyc(FILT + 10);
        chk({cmp_en, sys_rst}, 2'b00);
        @(posedge aclk) {below_rst, above_rel, rst_sel} <= 4'b0110;
        cyc(3);
        chk(cmp_en, 1'b1);
        // a dip shorter than the filter must not reset
        @(posedge aclk) {below_rst, above_rel} <= 2'b10;
        cyc(4);
        @(posedge aclk) {below_rst, above_rel} <= 2'b01;
        cyc(FILT + 6);
        chk(sys_rst, 1'b0);
        @(posedge aclk) below_det <= 1'b1;
        cyc(6);
        @(posedge aclk) {below_rst, above_rel, below_det} <= 3'b100;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (sys_rst !== 1'b1);
        chk(n >= FILT && n <= FILT + 5, 1'b1);
        cyc(20);
        chk(sys_rst, 1'b1);
        @(posedge aclk) {below_rst, above_rel} <= 2'b01;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (sys_rst !== 1'b0);
        chk(n <= 6, 1'b1);
        rdchk(`LVD_ADDR_STAT, 32'h81, `LVD_RESP_OKAY);
    endtask : t_lvr

    task automatic give_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        give_verdict();
    end

    // reset, then the scenarios in order
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
        {below_rst, above_rel, below_det, low_xtal, rst_sel} = 6'h12;
        {g_on, g_off, sleep, adc_evt, cmp_evt} = 5'h00;
        {n_mismatch, check_count, n_wake} = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_option();
        t_ctrl();
        t_detect();
        t_lvr();
        give_verdict();
    end
endmodule : low_voltage_detect_reset_tb
